// *** rtl/twm_params.svh ***
`ifndef TWM_PARAMS_SVH
`define TWM_PARAMS_SVH

// core clock rate in hertz
`define TWM_CLK_HZ       50000000
// selectable bus clock rates in hertz
`define TWM_F_100K       100000
`define TWM_F_400K       400000
`define TWM_F_800K       800000
`define TWM_F_1M         1000000
// quarter bit period in core cycles, rounded up so the bus never runs fast
`define TWM_QTR(f)       ((`TWM_CLK_HZ + 4 * (f) - 1) / (4 * (f)))
// divider counter width, holds the slowest quarter count
`define TWM_DIV_W        8
// byte count width, up to 127 bytes per phase
`define TWM_LEN_W        7
// bit slot index of the acknowledge bit
`define TWM_ACK_BIT      4'h8
// quarter phases inside one bit slot
`define TWM_PH_0         2'h0
`define TWM_PH_1         2'h1
`define TWM_PH_2         2'h2
`define TWM_PH_3         2'h3

`endif

// *** rtl/twm_pkg.sv ***
package twm_pkg;

  // bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_BIT,
    ST_WAIT,
    ST_STOP
  } twm_state_t;

  // transfer kinds
  typedef enum logic [1:0] {
    XF_READ,
    XF_WRITE,
    XF_RD_WR,
    XF_WR_RD
  } twm_xfer_t;

  // bus clock rate select
  typedef enum logic [1:0] {
    SP_100K,
    SP_400K,
    SP_800K,
    SP_1M
  } twm_speed_t;

endpackage

// *** rtl/twm_sync.sv ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// three stage pin synchroniser; output moves only when stages two and three agree
module twm_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             i_core_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level
);

  // one identical chain per line
  for (genvar g = 0; g < WIDTH; g++) begin : g_line
    logic s1_ff;   // metastable stage, read only by s2_ff
    logic s2_ff;   // second stage
    logic s3_ff;   // third stage
    logic out_ff;  // filtered level

    // lines idle high because of the external pull-ups
    always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
        s1_ff  <= 1'b1;
        s2_ff  <= 1'b1;
        s3_ff  <= 1'b1;
        out_ff <= 1'b1;
      end else begin
        s1_ff <= i_pin[g];
        s2_ff <= s1_ff;
        s3_ff <= s2_ff;
        // a one-cycle disagreement is treated as noise
        if (s2_ff == s3_ff) begin
          out_ff <= s3_ff;
        end
      end
    end

    assign o_level[g] = out_ff;
  end

endmodule

// *** rtl/twm_clkgen.sv ***
`timescale 1ns/1ps
`include "twm_params.svh"

////////////////////////////////////////////////////////////////////////////////
// quarter bit tick generator; one pulse per quarter of a bus clock period
module twm_clkgen (
  input  wire logic                 i_core_clk,
  input  wire logic                 i_rst,
  input  wire twm_pkg::twm_speed_t  i_speed,
  output logic                      o_tick
);

  logic [`TWM_DIV_W-1:0] cnt_ff;      // cycles left in this quarter
  logic [`TWM_DIV_W-1:0] nxt_reload;  // reload value for the chosen rate

  // reload picks the rate; a change takes effect at the next quarter
  always_comb begin
    case (i_speed)
      twm_pkg::SP_100K: nxt_reload = `TWM_DIV_W'(`TWM_QTR(`TWM_F_100K) - 1);
      twm_pkg::SP_400K: nxt_reload = `TWM_DIV_W'(`TWM_QTR(`TWM_F_400K) - 1);
      twm_pkg::SP_800K: nxt_reload = `TWM_DIV_W'(`TWM_QTR(`TWM_F_800K) - 1);
      twm_pkg::SP_1M:   nxt_reload = `TWM_DIV_W'(`TWM_QTR(`TWM_F_1M) - 1);
      default:          nxt_reload = `TWM_DIV_W'(`TWM_QTR(`TWM_F_100K) - 1);
    endcase
  end

  // free running down counter
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
    end else if (cnt_ff == '0) begin
      cnt_ff <= nxt_reload;
    end else begin
      cnt_ff <= cnt_ff - `TWM_DIV_W'(1);
    end
  end

  assign o_tick = (cnt_ff == '0);

endmodule

// *** rtl/twm_master.sv ***
`timescale 1ns/1ps
`include "twm_params.svh"

// How it works
// R1 - sole master of clock and data lines
// R2 - no arbitration; assumes single bus master
// R3 - ignores slave clock stretching, fixed bit timing
// R4 - offers 100 kHz and 400 kHz rates
// R5 - also offers 800 kHz and 1 MHz
// R6 - plain read, up to 127 bytes
// R7 - plain write, up to 127 bytes
// R8 - read then write, lengths set separately
// R9 - write then read, lengths set separately
// R10 - hardware sequences whole transfer after start
// R11 - open-drain pads: pull low or release
// R12 - repeated start between phases, stop at end
// R13 - ack all but last read byte; flag nacks
module twm_master #(
  parameter int LEN_W = `TWM_LEN_W
) (
  input  wire logic                i_core_clk,
  input  wire logic                i_rst,
  input  wire logic                i_start,
  input  wire twm_pkg::twm_xfer_t  i_xfer,
  input  wire twm_pkg::twm_speed_t i_speed,
  input  wire logic [6:0]          i_slave_addr,
  input  wire logic [LEN_W-1:0]    i_len1,
  input  wire logic [LEN_W-1:0]    i_len2,
  input  wire logic [7:0]          i_wr_data,
  input  wire logic                i_wr_valid,
  output logic                     o_wr_ready,
  output logic [7:0]               o_rd_data,
  output logic                     o_rd_valid,
  output logic                     o_busy,
  output logic                     o_done,
  output logic                     o_nack_err,
  input  wire logic                i_scl,
  output logic                     o_scl_out,
  output logic                     o_scl_oe,
  input  wire logic                i_sda,
  output logic                     o_sda_out,
  output logic                     o_sda_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  twm_pkg::twm_state_t state_ff;      // sequencer state
  twm_pkg::twm_state_t nxt_state;     // next sequencer state
  twm_pkg::twm_state_t nxt_after;     // where a finished byte leads
  logic [1:0]          phase_ff;      // quarter inside bit slot
  logic [3:0]          bit_ff;        // bit slot, ack is the last
  logic [7:0]          shift_ff;      // outgoing or incoming byte
  logic                samp_ff;       // data line sampled with clock high
  logic                is_addr_ff;    // current byte is the address
  logic                dir_rd_ff;     // current phase reads
  logic                second_ff;     // a second phase is still to come
  logic [LEN_W-1:0]    cnt_ff;        // bytes left in this phase
  logic [LEN_W-1:0]    len2_ff;       // length of second phase
  logic [LEN_W-1:0]    nxt_left;      // bytes left once this byte ends
  logic [6:0]          addr_ff;       // captured slave address
  logic                scl_low_ff;    // pulling clock low
  logic                sda_low_ff;    // pulling data low
  logic                busy_ff;       // transfer in progress
  logic                done_ff;       // end of stop pulse
  logic                err_ff;        // slave failed to acknowledge
  logic [7:0]          rd_data_ff;    // last received byte
  logic                rd_valid_ff;   // received byte pulse
  logic                tick;          // quarter bit strobe
  logic [1:0]          line;          // synchronised {scl, sda}
  logic                rx_byte;       // data byte driven by the slave
  logic                last_rd;       // final byte of a read phase
  logic                bit_end;       // end of any bit slot
  logic                byte_end;      // end of the ack slot
  logic                nack;          // slave left ack high
  logic                drive_low;     // data level for this slot
  logic                start_q;       // start accepted this cycle

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // rate divider; all four rates come from the same counter
  twm_clkgen u_clkgen (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_speed    (i_speed),      // R4 R5
    .o_tick     (tick)
  );

  // pin sampling; only the data level feeds the logic because stretching is ignored, the clock level feeds a check
  twm_sync #(
    .WIDTH (2)
  ) u_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_pin      ({i_scl, i_sda}),
    .o_level    (line)
  );

  assign start_q   = i_start && (state_ff == twm_pkg::ST_IDLE);
  assign rx_byte   = dir_rd_ff && !is_addr_ff;
  assign last_rd   = (cnt_ff == LEN_W'(1));
  assign bit_end   = tick && (state_ff == twm_pkg::ST_BIT) && (phase_ff == `TWM_PH_3);
  assign byte_end  = bit_end && (bit_ff == `TWM_ACK_BIT);
  // a high ack on a byte we sent is a refusal
  assign nack      = !rx_byte && samp_ff;                       // R13
  assign nxt_left  = is_addr_ff ? cnt_ff : cnt_ff - LEN_W'(1);
  // master acks every received byte but the last one
  assign drive_low = (bit_ff == `TWM_ACK_BIT) ? (rx_byte && !last_rd)    // R13
                                              : (!rx_byte && !shift_ff[7]);

  ////////////////////////////////////////////////////////////////////////////
  // sequencing

  // what follows a finished byte
  always_comb begin
    if (nack) begin
      nxt_after = twm_pkg::ST_STOP;                             // R13
    end else if (nxt_left != '0) begin
      // writes wait for the user byte, reads go straight on
      nxt_after = dir_rd_ff ? twm_pkg::ST_BIT : twm_pkg::ST_WAIT;
    end else if (second_ff) begin
      nxt_after = twm_pkg::ST_START;                            // R12 R8 R9
    end else begin
      nxt_after = twm_pkg::ST_STOP;                             // R12
    end
  end

  // state walk; no wait on the clock line, slaves must keep pace
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      twm_pkg::ST_IDLE: begin
        if (i_start) begin
          nxt_state = twm_pkg::ST_START;                        // R10
        end
      end
      twm_pkg::ST_START: begin
        if (tick && phase_ff == `TWM_PH_3) begin
          nxt_state = twm_pkg::ST_BIT;
        end
      end
      twm_pkg::ST_BIT: begin
        if (byte_end) begin
          nxt_state = nxt_after;                                // R3
        end
      end
      twm_pkg::ST_WAIT: begin
        if (i_wr_valid) begin
          nxt_state = twm_pkg::ST_BIT;                          // R7
        end
      end
      twm_pkg::ST_STOP: begin
        if (tick && phase_ff == `TWM_PH_3) begin
          nxt_state = twm_pkg::ST_IDLE;
        end
      end
      default: nxt_state = twm_pkg::ST_IDLE;
    endcase
  end

  // state, quarter and bit slot counters
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= twm_pkg::ST_IDLE;
      phase_ff <= `TWM_PH_0;
      bit_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff) begin
        phase_ff <= `TWM_PH_0;
        bit_ff   <= '0;
      end else begin
        if (tick) begin
          phase_ff <= phase_ff + 2'h1;
        end
        // slot count wraps after the ack, also when a read goes straight on
        if (byte_end) begin
          bit_ff <= '0;
        end else if (bit_end) begin
          bit_ff <= bit_ff + 4'h1;
        end
      end
    end
  end

  // transfer setup captured at start; direction flips at the repeated start
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      addr_ff   <= '0;
      dir_rd_ff <= 1'b0;
      second_ff <= 1'b0;
      len2_ff   <= '0;
      cnt_ff    <= '0;
    end else if (start_q) begin
      addr_ff   <= i_slave_addr;
      dir_rd_ff <= (i_xfer == twm_pkg::XF_READ) || (i_xfer == twm_pkg::XF_RD_WR); // R6 R8
      second_ff <= (i_xfer == twm_pkg::XF_RD_WR) || (i_xfer == twm_pkg::XF_WR_RD); // R8 R9
      len2_ff   <= i_len2;
      cnt_ff    <= i_len1;
    end else if (byte_end && nxt_after == twm_pkg::ST_START) begin
      dir_rd_ff <= !dir_rd_ff;                                  // R8 R9
      second_ff <= 1'b0;
      cnt_ff    <= len2_ff;
    end else if (byte_end) begin
      cnt_ff    <= nxt_left;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // byte datapath

  // shifter: address, user byte, or bits coming in
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      shift_ff   <= '0;
      is_addr_ff <= 1'b0;
      samp_ff    <= 1'b1;
    end else begin
      if (state_ff == twm_pkg::ST_START && nxt_state == twm_pkg::ST_BIT) begin
        shift_ff   <= {addr_ff, dir_rd_ff};                     // R12
        is_addr_ff <= 1'b1;
      end else if (o_wr_ready && i_wr_valid) begin
        shift_ff   <= i_wr_data;                                // R7
      end else if (bit_end && bit_ff != `TWM_ACK_BIT) begin
        shift_ff   <= {shift_ff[6:0], samp_ff};                 // R6
      end
      if (byte_end) begin
        is_addr_ff <= 1'b0;
      end
      // sampled mid clock-high, clock line checked only by a_clock_kept_high
      if (tick && state_ff == twm_pkg::ST_BIT && phase_ff == `TWM_PH_2) begin
        samp_ff <= line[0];                                     // R3
      end
    end
  end

  // read byte hand-off, one pulse per received byte
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_data_ff  <= '0;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= byte_end && rx_byte;                       // R6 R8 R9
      if (byte_end && rx_byte) begin
        rd_data_ff <= shift_ff;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line drive; every action lands at the end of a quarter

  // no arbitration loss check: the data line is never compared to what we send
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_low_ff <= 1'b0;
      sda_low_ff <= 1'b0;
    end else if (tick) begin
      case (state_ff)
        twm_pkg::ST_START: begin
          // release both, then data falls while clock is high
          case (phase_ff)
            `TWM_PH_0: sda_low_ff <= 1'b0;
            `TWM_PH_1: scl_low_ff <= 1'b0;
            `TWM_PH_2: sda_low_ff <= 1'b1;                      // R12
            default:   scl_low_ff <= 1'b1;
          endcase
        end
        twm_pkg::ST_BIT: begin
          case (phase_ff)
            `TWM_PH_0: sda_low_ff <= drive_low;                 // R11 R2
            `TWM_PH_1: scl_low_ff <= 1'b0;
            `TWM_PH_3: scl_low_ff <= 1'b1;
            default:   scl_low_ff <= scl_low_ff;
          endcase
        end
        twm_pkg::ST_STOP: begin
          // data rises while clock is high
          case (phase_ff)
            `TWM_PH_0: sda_low_ff <= 1'b1;
            `TWM_PH_1: scl_low_ff <= 1'b0;
            `TWM_PH_2: sda_low_ff <= 1'b0;                      // R12
            default:   sda_low_ff <= 1'b0;
          endcase
        end
        default: begin
          // clock stays low while waiting for write data
          scl_low_ff <= scl_low_ff;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status

  // busy, done pulse and sticky refusal flag cleared by the next start
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      err_ff  <= 1'b0;
    end else begin
      busy_ff <= (nxt_state != twm_pkg::ST_IDLE);               // R10
      done_ff <= tick && state_ff == twm_pkg::ST_STOP && phase_ff == `TWM_PH_3;
      if (start_q) begin
        err_ff <= 1'b0;
      end else if (byte_end && nack) begin
        err_ff <= 1'b1;                                         // R13
      end
    end
  end

  // open-drain: the output level is always low, the enable pulls
  assign o_scl_out  = 1'b0;                                     // R11
  assign o_sda_out  = 1'b0;                                     // R11
  assign o_scl_oe   = scl_low_ff;                               // R1
  assign o_sda_oe   = sda_low_ff;
  assign o_wr_ready = (state_ff == twm_pkg::ST_WAIT);
  assign o_rd_data  = rd_data_ff;
  assign o_rd_valid = rd_valid_ff;
  assign o_busy     = busy_ff;
  assign o_done     = done_ff;
  assign o_nack_err = err_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_pads_open_drain: assert property ( // R11
    @(posedge i_core_clk) disable iff (i_rst) !o_scl_out && !o_sda_out)
    else $error("pad driven high");

  a_idle_released: assert property ( // R1
    @(posedge i_core_clk) disable iff (i_rst)
    (state_ff == twm_pkg::ST_IDLE) |-> (!o_scl_oe && !o_sda_oe))
    else $error("lines held while idle");

  a_stop_at_end: assert property ( // R12
    @(posedge i_core_clk) disable iff (i_rst)
    o_done |-> (!o_scl_oe && !o_sda_oe && $past(state_ff) == twm_pkg::ST_STOP))
    else $error("done without stop");

  a_nack_flagged: assert property ( // R13
    @(posedge i_core_clk) disable iff (i_rst)
    (byte_end && !rx_byte && samp_ff) |=> (o_nack_err && state_ff == twm_pkg::ST_STOP))
    else $error("nack not flagged");

  a_last_not_acked: assert property ( // R13
    @(posedge i_core_clk) disable iff (i_rst)
    (tick && state_ff == twm_pkg::ST_BIT && phase_ff == `TWM_PH_0
     && bit_ff == `TWM_ACK_BIT && rx_byte)
    |=> (o_sda_oe == !last_rd))
    else $error("wrong ack on read byte");

  a_write_taken: assert property ( // R7
    @(posedge i_core_clk) disable iff (i_rst)
    (o_wr_ready && i_wr_valid) |=> (state_ff == twm_pkg::ST_BIT && bit_ff == 4'h0))
    else $error("write byte not sent");

  a_tick_spacing: assert property ( // R4
    @(posedge i_core_clk) disable iff (i_rst)
    tick |=> !tick [*8])
    else $error("bus clock too fast");

  a_start_busy: assert property ( // R10
    @(posedge i_core_clk) disable iff (i_rst)
    start_q |=> (o_busy && state_ff == twm_pkg::ST_START) ##1 o_busy)
    else $error("start not sequenced");

  a_no_stretch: assert property ( // R3
    @(posedge i_core_clk) disable iff (i_rst)
    (tick && state_ff == twm_pkg::ST_BIT && phase_ff == `TWM_PH_1)
    |=> (phase_ff == `TWM_PH_2 && !o_scl_oe))
    else $error("clock waited on slave");

  // slaves must keep pace: the clock has risen by the time data is sampled
  a_clock_kept_high: assert property ( // R3
    @(posedge i_core_clk) disable iff (i_rst)
    (tick && state_ff == twm_pkg::ST_BIT && phase_ff == `TWM_PH_2) |-> line[1])
    else $error("clock held low by slave");

  a_restart_flips: assert property ( // R12
    @(posedge i_core_clk) disable iff (i_rst)
    (byte_end && nxt_after == twm_pkg::ST_START) |=> (dir_rd_ff != $past(dir_rd_ff)))
    else $error("second phase keeps direction");

endmodule

// *** dv/twm_slave_model.sv ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// behavioural bus slave; answers at once and never holds the clock low
module twm_slave_model #(
  parameter logic [6:0] ADDR = 7'h5A  // our bus address, arbitrary
) (
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_oe
);
  logic [7:0] rxq[$];    // bytes written to us
  logic [7:0] txq[$];    // bytes handed out on reads
  logic [7:0] sh;        // receive shifter
  logic [7:0] txb;       // byte being sent
  logic       nx;        // next pull-down
  int         bits;      // bit slot in the frame
  int         acks;      // master acks seen
  int         nacks;     // master nacks seen
  bit         act;       // addressed and in a frame
  bit         adr;       // next byte is the address
  bit         rd;        // we are the sender
  bit         snd;       // keep sending
  bit         mslot;     // ack slot belongs to the master
  bit         nack_data; // refuse written bytes
  initial begin
    o_sda_oe = 1'b0;
    act = 0;
  end
  // start or repeated start: data falls while clock high
  always @(negedge i_sda) begin
    if (i_scl === 1'b1) begin
      act = 1;
      adr = 1;
      rd = 0;
      snd = 0;
      bits = 0;
    end
  end
  // stop: data rises while clock high
  always @(posedge i_sda) begin
    if (i_scl === 1'b1) begin
      act = 0;
    end
  end
  // sample on rising clock; no stretching, we keep pace with the master
  always @(posedge i_scl) begin
    if (act) begin
      if (bits < 8) sh = {sh[6:0], i_sda};
      if (bits == 8 && mslot) begin
        mslot = 0;
        snd = !i_sda;
        if (snd) acks++;
        else nacks++;
      end
      bits++;
    end
  end
  // change data only after the clock falls; released line floats high
  always @(negedge i_scl) begin
    nx = 1'b0;
    if (act) begin
      if (bits == 9) begin
        bits = 0;
        if (rd && snd) txb = (txq.size() > 0) ? txq.pop_front() : 8'hA5;
      end
      if (bits == 8) begin
        if (adr) begin
          adr = 0;
          act = (sh[7:1] == ADDR);
          rd = sh[0];
          snd = rd;
          nx = act;
        end else if (!rd) begin
          rxq.push_back(sh);
          nx = !nack_data;
        end else mslot = 1;
      end
      if (bits < 8 && rd && snd) nx = !txb[7 - bits];
    end
    o_sda_oe = nx;
  end
endmodule

// *** dv/two_wire_serial_master_tb.sv ***
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// runs every transfer kind and rate against the slave model
module two_wire_serial_master_tb;
  localparam logic [6:0] SLV = 7'h5A;  // slave address, arbitrary
  localparam int FR [4] = '{100000, 400000, 800000, 1000000}; // rate by speed code
  logic       clk, rst, start, wr_valid, wr_ready, rd_valid, busy, done, nack_err;
  logic [1:0] xfer, speed;
  logic [6:0] addr, len1, len2;
  logic [7:0] wr_data, rd_data;
  logic       scl_out, scl_oe, sda_out, sda_oe, slv_oe;
  wire        scl = ~scl_oe;            // pull-ups on both lines
  wire        sda = ~(sda_oe | slv_oe);
  int         err_count, checked, cycles, n_start, n_stop, n_done;
  logic [7:0] wq[$], ew[$], er[$];      // to send, expected at slave, expected reads
  longint     tq[$];                    // clock rise times

  twm_master dut (.i_core_clk(clk), .i_rst(rst), .i_start(start),
    .i_xfer(twm_pkg::twm_xfer_t'(xfer)), .i_speed(twm_pkg::twm_speed_t'(speed)),
    .i_slave_addr(addr), .i_len1(len1), .i_len2(len2), .i_wr_data(wr_data),
    .i_wr_valid(wr_valid), .o_wr_ready(wr_ready), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_busy(busy), .o_done(done), .o_nack_err(nack_err),
    .i_scl(scl), .o_scl_out(scl_out), .o_scl_oe(scl_oe), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe(sda_oe));
  twm_slave_model #(.ADDR(SLV)) slv (.i_scl(scl), .i_sda(sda), .o_sda_oe(slv_oe));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // bus watchers: start, stop and clock rises
  always @(negedge sda) if (scl === 1'b1) n_start++;
  always @(posedge sda) if (scl === 1'b1) n_stop++;
  always @(posedge scl) tq.push_back($time);

  // hang guard and write byte hand-off
  always @(posedge clk) begin
    if (wr_ready === 1'b1 && wr_valid) void'(wq.pop_front());
    cycles++;
    if (cycles > 60000) begin
      err_count++;
      give_verdict();
    end
  end

  // drive at the falling edge, look at settled outputs
  always @(negedge clk) begin
    wr_valid = (wq.size() > 0);
    wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
    if (rd_valid === 1'b1) chk_byte(rd_data, (er.size() > 0) ? er.pop_front() : 8'hXX);
    if (done === 1'b1) n_done++;
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: byte %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: %s is %b", $time, what, got);
    end
  endtask

  task automatic chk_cnt(input int got, input int exp, input string what);
    checked++;
    if (got != exp) begin
      err_count++;
      $display("wrong value at %0t ns: %s %0d, expected %0d", $time, what, got, exp);
    end
  endtask

  // one transfer: k 0 read, 1 write, 2 read-write, 3 write-read; nd refuses data
  task automatic run(input int k, input int s, input logic [6:0] a,
                     input int l1, input int l2, input bit nd);
    int  n, q, ea, ek, t;
    bit  r, ex, an, rd1, ph2;
    logic [7:0] b;
    rd1 = (k == 0 || k == 2);
    an = (a != SLV);
    ph2 = (k >= 2) && !an && !nd;
    ea = 0;
    ek = 0;
    slv.nack_data = nd;
    slv.rxq.delete();
    slv.acks = 0;
    slv.nacks = 0;
    // reference model: what each phase should carry
    for (int p = 0; p < 2; p++) begin
      n = p ? l2 : l1;
      r = p ? !rd1 : rd1;
      ex = p ? ph2 : !an;
      for (int j = 0; ex && j < n; j++) begin
        b = 8'($urandom);
        if (r) slv.txq.push_back(b);
        if (r) er.push_back(b);
        if (!r) wq.push_back(b);
        if (!r && (!nd || j == 0)) ew.push_back(b);
      end
      if (ex && r && n > 0) ea++;
      if (ex && r && n > 0) ek += n - 1;
    end
    tq.delete();
    n_start = 0;
    n_stop = 0;
    n_done = 0;
    @(negedge clk);
    xfer = 2'(k);
    speed = 2'(s);
    addr = a;
    len1 = 7'(l1);
    len2 = 7'(l2);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    // a request while busy must be dropped
    repeat (5) @(negedge clk);
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    t = 0;
    while (n_done == 0 && t < 40000) begin
      @(posedge clk);
      t++;
    end
    repeat (3) @(negedge clk);
    q = (50000000 + 4 * FR[s] - 1) / (4 * FR[s]);
    chk_cnt(n_done, 1, "done pulses");
    chk_flag(busy, 1'b0, "busy");
    chk_flag(nack_err, an || nd, "nack flag");
    chk_cnt(n_start, ph2 ? 2 : 1, "starts");
    chk_cnt(n_stop, 1, "stops");
    chk_cnt(int'(tq[1] - tq[0]), 80 * q, "bit period ns");
    chk_cnt(slv.rxq.size(), ew.size(), "bytes at slave");
    foreach (ew[i]) if (i < slv.rxq.size()) chk_byte(slv.rxq[i], ew[i]);
    chk_cnt(er.size(), 0, "reads missing");
    chk_cnt(slv.acks, ek, "master acks");
    chk_cnt(slv.nacks, ea, "master nacks");
    chk_flag(scl_out | sda_out | scl_oe | sda_oe, 1'b0, "pads");
    wq.delete();
    ew.delete();
    er.delete();
    slv.txq.delete();
    $display("test kind %0d speed %0d ended, errors so far %0d", k, s, err_count);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(91208));
    rst = 1'b1;
    start = 1'b0;
    xfer = 2'h0;
    speed = 2'h3;
    addr = SLV;
    len1 = 7'h00;
    len2 = 7'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk_flag(scl_oe | sda_oe | busy | done | nack_err, 1'b0, "reset outputs");
    run(1, 0, SLV, 1, 0, 0);
    run(0, 1, SLV, 1 + $urandom % 4, 0, 0);
    run(2, 2, SLV, 2, 1 + $urandom % 3, 0);
    run(3, 3, SLV, 1 + $urandom % 3, 2, 0);
    run(1, 3, SLV, 0, 0, 0);
    run(0, 3, SLV ^ 7'h01, 2, 0, 0);
    run(3, 3, SLV, 3, 2, 1);
    run(3, 3, SLV, 0, 1, 0);
    give_verdict();
  end
endmodule
